/* File: core/slc_mode_cfg.v */
`timescale 1ns/100ps
`include "slc_regs.vh"

module slc_mode_cfg (
  input  wire        CORE_CLK_I,
  input  wire        RSTN_I,
  input  wire [2:0]  SPREAD_SEL_I,
  input  wire [2:0]  BOOST_SEL_I,
  input  wire [2:0]  PWIDTH_I,
  input  wire [2:0]  WORD_LEN_I,
  input  wire [1:0]  SERIAL_RATE_RANGE_I,
  input  wire [1:0]  PIXEL_RATE_RANGE_I,
  input  wire        VSYNC_RISE_SEL_I,
  input  wire        HSYNC_RISE_SEL_I,
  input  wire        VSYNC_I,
  input  wire        HSYNC_I,
  input  wire [9:0]  GPIO_DIR_I,
  input  wire [9:0]  GPIO_WDATA_I,
  input  wire        GPIO_WE_I,
  input  wire [9:0]  GPIO_IN_I,
  input  wire        PERIPHERAL_ENABLE_I,
  input  wire        INTERFACE_SELECT_I,
  input  wire        MODE_WE_I,
  input  wire [2:0]  BYPASS_RETURN_TIMEOUT_I,
  input  wire        UART_BIT_TICK_I,
  input  wire        ECU_ACTIVITY_I,
  input  wire [3:0]  START_TIMEOUT_PRESCALE_I,
  input  wire [3:0]  START_TIMEOUT_COUNT_I,
  input  wire        CC_CLOSE_I,
  input  wire        PKT_VALID_I,
  input  wire        PKT_FOR_LINK_I,
  input  wire        I2C_RESP_VALID_I,
  input  wire        LOCKED_I,
  input  wire        ERR_I,
  input  wire        SHUTDOWN_I,
  output reg         SPREAD_EN_O,
  output reg  [8:0]  SPREAD_PCT_X100_O,
  output reg  [6:0]  BOOST_PCT_O,
  output reg  [11:0] MOD_DIV_O,
  output wire [10:0] SPREAD_TRI_O,
  output reg         HSYNC_O,
  output reg  [9:0]  GPIO_AVAIL_O,
  output reg  [9:0]  GPIO_OUT_O,
  output reg  [9:0]  GPIO_OE_O,
  output reg  [9:0]  GPIO_LEVEL_O,
  output reg         PERIPHERAL_ENABLE_O,
  output reg         INTERFACE_SELECT_O,
  output reg         BYPASS_MODE_O,
  output reg         CC_OPEN_O,
  output reg         STO_EXPIRED_O,
  output reg         I2C_FWD_O,
  output reg         UART_RESP_O,
  output reg         LINK_REG_ACCESS_O,
  output reg         LOCK_O,
  output reg         LOCK_OE_O,
  output reg         ERROR_O,
  output reg         ERROR_OE_O
);

  // ****************************************
  // Decode functions
  // ****************************************
  function [8:0] spread_pct;
    input [2:0] code;
    begin
      case (code)
        3'h1:    spread_pct = 9'h096;
        3'h2:    spread_pct = 9'h0AF;
        3'h3:    spread_pct = 9'h0C8;
        3'h5:    spread_pct = 9'h12C;
        3'h6:    spread_pct = 9'h15E;
        3'h7:    spread_pct = 9'h190;
        default: spread_pct = 9'h000;
      endcase
    end
  endfunction

  function [6:0] boost_pct;
    input [2:0] code;
    begin
      case (code)
        3'h1:    boost_pct = 7'h28;
        3'h2:    boost_pct = 7'h3C;
        3'h3:    boost_pct = 7'h50;
        3'h4:    boost_pct = 7'h64;
        3'h7:    boost_pct = 7'h00;
        default: boost_pct = 7'h14;
      endcase
    end
  endfunction

  // Ranges missing from the table give zero, which stops the generator
  function [11:0] mod_div;
    input [2:0] wl;
    input [1:0] sr;
    input [1:0] pr;
    begin
      case ({wl, sr, pr})
        {`SLC_WL_12, 4'hF}: mod_div = 12'hAA8;
        {`SLC_WL_12, 4'hE}: mod_div = 12'h6C8;
        {`SLC_WL_12, 4'hA}: mod_div = 12'h64C;
        {`SLC_WL_12, 4'h9}: mod_div = 12'h3E0;
        {`SLC_WL_12, 4'h5}: mod_div = 12'h45C;
        {`SLC_WL_12, 4'h4}: mod_div = 12'h2E8;
        {`SLC_WL_12, 4'h0}: mod_div = 12'h364;
        {`SLC_WL_14, 4'hF}: mod_div = 12'h900;
        {`SLC_WL_14, 4'hE}: mod_div = 12'h6C0;
        {`SLC_WL_14, 4'hA}: mod_div = 12'h5A0;
        {`SLC_WL_14, 4'h9}: mod_div = 12'h3F0;
        {`SLC_WL_14, 4'h5}: mod_div = 12'h3F0;
        {`SLC_WL_14, 4'h4}: mod_div = 12'h2D0;
        {`SLC_WL_14, 4'h0}: mod_div = 12'h2D0;
        {`SLC_WL_16, 4'hF}: mod_div = 12'h7B0;
        {`SLC_WL_16, 4'hE}: mod_div = 12'h668;
        {`SLC_WL_16, 4'hA}: mod_div = 12'h520;
        {`SLC_WL_16, 4'h9}: mod_div = 12'h3D8;
        {`SLC_WL_16, 4'h5}: mod_div = 12'h334;
        {`SLC_WL_16, 4'h4}: mod_div = 12'h290;
        {`SLC_WL_16, 4'h0}: mod_div = 12'h290;
        {`SLC_WL_18, 4'hF}: mod_div = 12'h730;
        {`SLC_WL_18, 4'hE}: mod_div = 12'h5C0;
        {`SLC_WL_18, 4'hA}: mod_div = 12'h450;
        {`SLC_WL_18, 4'h9}: mod_div = 12'h398;
        {`SLC_WL_18, 4'h5}: mod_div = 12'h2E0;
        {`SLC_WL_18, 4'h4}: mod_div = 12'h2E0;
        {`SLC_WL_18, 4'h0}: mod_div = 12'h228;
        {`SLC_WL_20, 4'hF}: mod_div = 12'h660;
        {`SLC_WL_20, 4'hE}: mod_div = 12'h660;
        {`SLC_WL_20, 4'h9}: mod_div = 12'h3FC;
        {`SLC_WL_20, 4'h4}: mod_div = 12'h330;
        default:            mod_div = 12'h000;
      endcase
    end
  endfunction

  function [9:0] gpio_mask;
    input [2:0] pw;
    begin
      case (pw)
        3'h0:    gpio_mask = `SLC_GPIO_ALL;
        3'h1:    gpio_mask = `SLC_GPIO_W12;
        3'h2:    gpio_mask = `SLC_GPIO_W14;
        3'h3:    gpio_mask = `SLC_GPIO_W16;
        default: gpio_mask = `SLC_GPIO_W18;
      endcase
    end
  endfunction

  // Terminal value of the prescaler, one less than the divide ratio
  function [14:0] sto_term;
    input [3:0] code;
    begin
      case (code)
        4'h5:    sto_term = 15'h001F;
        4'h6:    sto_term = 15'h003F;
        4'h7:    sto_term = 15'h007F;
        4'h8:    sto_term = 15'h00FF;
        4'h9:    sto_term = 15'h01FF;
        4'hA:    sto_term = 15'h03FF;
        4'hB:    sto_term = 15'h07FF;
        4'hC:    sto_term = 15'h0FFF;
        4'hD:    sto_term = 15'h1FFF;
        4'hE:    sto_term = 15'h3FFF;
        4'hF:    sto_term = 15'h7FFF;
        default: sto_term = 15'h000F;
      endcase
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [1:0] vs_sync_r;
  reg [1:0] hs_sync_r;
  reg [9:0] gpio_s1_r;
  reg [9:0] gpio_s2_r;
  reg       vs_prev_r;

  always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      vs_sync_r <= 2'h0;
      hs_sync_r <= 2'h0;
      gpio_s1_r <= 10'h000;
      gpio_s2_r <= 10'h000;
      vs_prev_r <= 1'b0;
    end else begin
      vs_sync_r <= {vs_sync_r[0], VSYNC_I};
      hs_sync_r <= {hs_sync_r[0], HSYNC_I};
      gpio_s1_r <= GPIO_IN_I;
      gpio_s2_r <= gpio_s1_r;
      vs_prev_r <= vs_sync_r[1];
    end
  end

  wire vs_edge;
  assign vs_edge = VSYNC_RISE_SEL_I ? (vs_sync_r[1] & ~vs_prev_r) // see R3
                                    : (~vs_sync_r[1] & vs_prev_r); // see R2

  // ****************************************
  // Spread, preemphasis and GPIO
  // ****************************************
  wire [9:0] avail;
  wire [9:0] gpio_level_nxt;
  assign avail = gpio_mask(PWIDTH_I); // see R5

  // Bits outside the mask keep their last value and never reach a pin
  assign gpio_level_nxt = (avail & ~GPIO_DIR_I & gpio_s2_r) // see R7
                        | (avail & GPIO_DIR_I & (GPIO_WE_I ? GPIO_WDATA_I : GPIO_LEVEL_O))
                        | (~avail & GPIO_LEVEL_O); // see R6

  // Every decode is registered on the pixel clock
  always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      SPREAD_EN_O       <= 1'b0;
      SPREAD_PCT_X100_O <= 9'h000;
      BOOST_PCT_O       <= 7'h00;
      MOD_DIV_O         <= 12'h000;
      HSYNC_O           <= 1'b0;
      GPIO_AVAIL_O      <= 10'h000;
      GPIO_OUT_O        <= 10'h000;
      GPIO_OE_O         <= 10'h000;
      GPIO_LEVEL_O      <= 10'h000;
    end else begin
      SPREAD_PCT_X100_O <= spread_pct(SPREAD_SEL_I); // see R1, R24
      SPREAD_EN_O       <= (SPREAD_SEL_I[1:0] != 2'h0); // see R1
      BOOST_PCT_O       <= boost_pct(BOOST_SEL_I); // see R13
      MOD_DIV_O         <= mod_div(WORD_LEN_I, SERIAL_RATE_RANGE_I,
                                   PIXEL_RATE_RANGE_I); // see R8
      HSYNC_O           <= hs_sync_r[1] ^ HSYNC_RISE_SEL_I; // see R4
      GPIO_AVAIL_O      <= avail;
      GPIO_LEVEL_O      <= gpio_level_nxt; // see R7
      GPIO_OE_O         <= avail & GPIO_DIR_I; // see R6
      GPIO_OUT_O        <= avail & GPIO_DIR_I & gpio_level_nxt; // see R6
    end
  end

  slc_tri_gen u_tri (
    .clk_i  (CORE_CLK_I),
    .rstn_i (RSTN_I),
    .en_i   (SPREAD_EN_O),
    .div_i  (MOD_DIV_O),
    .tri_o  (SPREAD_TRI_O)
  );

  // ****************************************
  // Base and bypass mode
  // ****************************************
  reg  [`SLC_CTO_W-1:0] cto_cnt_r;
  wire [`SLC_CTO_W-1:0] cto_limit;
  wire                  bypass;
  wire                  cto_expire;
  wire                  periph_i2c;

  assign cto_limit  = {BYPASS_RETURN_TIMEOUT_I, 4'h0};
  assign bypass     = PERIPHERAL_ENABLE_O & ~INTERFACE_SELECT_O; // see R17
  assign periph_i2c = PERIPHERAL_ENABLE_O & INTERFACE_SELECT_O; // see R16, R17
  // Code zero never returns, which lets the controller stay in bypass
  assign cto_expire = bypass & (BYPASS_RETURN_TIMEOUT_I != 3'h0)
                    & (cto_cnt_r >= cto_limit) & ~ECU_ACTIVITY_I; // see R18, R19

  always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      PERIPHERAL_ENABLE_O <= `SLC_PE_RST; // see R16
      INTERFACE_SELECT_O  <= `SLC_IS_RST;
      BYPASS_MODE_O       <= 1'b0;
      cto_cnt_r           <= 7'h00;
      I2C_FWD_O           <= 1'b0;
      UART_RESP_O         <= 1'b0;
      LINK_REG_ACCESS_O   <= 1'b0;
    end else begin
      if (!bypass || ECU_ACTIVITY_I) begin
        cto_cnt_r <= 7'h00;
      end else if (UART_BIT_TICK_I && cto_cnt_r < cto_limit) begin
        cto_cnt_r <= cto_cnt_r + 7'h01;
      end
      // A software write in the expiry cycle takes precedence
      if (MODE_WE_I) begin
        PERIPHERAL_ENABLE_O <= PERIPHERAL_ENABLE_I;
        INTERFACE_SELECT_O  <= INTERFACE_SELECT_I;
        BYPASS_MODE_O       <= PERIPHERAL_ENABLE_I & ~INTERFACE_SELECT_I;
      end else if (cto_expire) begin
        PERIPHERAL_ENABLE_O <= 1'b0; // see R18
        BYPASS_MODE_O       <= 1'b0;
      end
      I2C_FWD_O         <= PKT_VALID_I & ~PKT_FOR_LINK_I & periph_i2c; // see R14
      UART_RESP_O       <= I2C_RESP_VALID_I & periph_i2c; // see R15
      LINK_REG_ACCESS_O <= PKT_VALID_I & PKT_FOR_LINK_I & ~bypass; // see R17
    end
  end

  // ****************************************
  // Control channel start timeout
  // ****************************************
  reg  [`SLC_PRE_W-1:0] pre_cnt_r;
  reg  [4:0]            sto_cnt_r;
  reg                   sto_run_r;
  wire                  pre_tick;
  wire [4:0]            sto_end;

  assign pre_tick = sto_run_r & (pre_cnt_r == sto_term(START_TIMEOUT_PRESCALE_I)); // see R20
  assign sto_end  = {1'b0, START_TIMEOUT_COUNT_I} + 5'h01;

  always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      pre_cnt_r     <= 15'h0000;
      sto_cnt_r     <= 5'h00;
      sto_run_r     <= 1'b0;
      CC_OPEN_O     <= 1'b0;
      STO_EXPIRED_O <= 1'b0;
    end else begin
      STO_EXPIRED_O <= 1'b0;
      if (!sto_run_r || pre_tick) begin
        pre_cnt_r <= 15'h0000;
      end else begin
        pre_cnt_r <= pre_cnt_r + 15'h0001; // see R24
      end
      if (vs_edge && !CC_OPEN_O) begin
        CC_OPEN_O <= 1'b1; // see R2, R3
        sto_run_r <= 1'b1;
        sto_cnt_r <= 5'h00;
      end else if (CC_CLOSE_I) begin
        CC_OPEN_O <= 1'b0;
        sto_run_r <= 1'b0;
      end else if (sto_run_r && ECU_ACTIVITY_I) begin
        sto_run_r <= 1'b0;
      end else if (pre_tick) begin
        if (sto_cnt_r + 5'h01 >= sto_end) begin
          sto_run_r     <= 1'b0; // see R21
          CC_OPEN_O     <= 1'b0;
          STO_EXPIRED_O <= 1'b1;
        end
        sto_cnt_r <= sto_cnt_r + 5'h01; // see R21
      end
    end
  end

  // ****************************************
  // Open-drain status outputs
  // ****************************************
  // Only the enables move, so several devices wire-AND on one pull-up
  always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      LOCK_O     <= 1'b0; // see R9
      ERROR_O    <= 1'b0; // see R9
      LOCK_OE_O  <= 1'b0;
      ERROR_OE_O <= 1'b0;
    end else begin
      LOCK_OE_O  <= ~SHUTDOWN_I & ~LOCKED_I; // see R10, R11, R12
      ERROR_OE_O <= ~SHUTDOWN_I & ERR_I; // see R10, R11, R12
    end
  end

endmodule

/* File: core/slc_regs.vh */
// Summary of operation
// R1: Output spread code 000/100 off; others select 1.5 to 4 percent.
// R2: Falling vertical sync edge opens the control channel by default.
// R3: Vertical sync active edge may be set to rising; mismatch still works.
// R4: Horizontal sync output active-edge polarity is programmable.
// R5: GPIO 8-9 always usable; lower GPIOs usable according to parallel width.
// R6: GPIO bits unavailable at current width have no effect on pins.
// R7: Available GPIO is output or input; one bit drives or captures level.
// R8: Spread modulation divisor chosen from word length, serial and pixel range.
// R9: Lock and error outputs only pull low or release.
// R10: Lock released while locked; error pulled low on an error.
// R11: Shutdown releases both status outputs; controller ignores lock then.
// R12: Status outputs of several devices combine as wired AND.
// R13: Preemphasis code decodes to 20, 40, 60, 80, 100 or 0 percent.
// R14: Base mode forwards packets for neither link device to I2C.
// R15: Base mode turns peripheral I2C responses into UART packets.
// R16: Base mode after reset; peripheral enable clear blocks peripheral traffic.
// R17: Enable plus select gives base I2C; enable without select gives bypass.
// R18: Bypass idle for return timeout clears peripheral enable to base mode.
// R19: Controller locks return timer or lengthens it to stay in bypass.
// R20: Start-timeout prescale divides by 16 for codes up to 0100, then doubles.
// R21: Start-timeout counter expires at programmed count plus one, closing channel.
// R22: Controller enables spread on at most one link device at a time.
// R23: Controller limits spread to 2 percent at pixel ranges 10 and 11.
// R24: All decoders and prescaler run synchronously on the pixel clock.
// R25: Spread generator makes symmetric triangle with period equal to divisor.
`ifndef SLC_REGS_VH
`define SLC_REGS_VH

// Reset values of the mode bits
`define SLC_PE_RST        1'b0
`define SLC_IS_RST        1'b1

// Serial word length codes
`define SLC_WL_12         3'h0
`define SLC_WL_14         3'h1
`define SLC_WL_16         3'h2
`define SLC_WL_18         3'h3
`define SLC_WL_20         3'h4

// Field widths
`define SLC_DIV_W         12
`define SLC_TRI_W         11
`define SLC_PRE_W         15

// Return timeout step in UART bit times, as a shift
`define SLC_CTO_SHIFT     4
`define SLC_CTO_W         7

// GPIO availability masks per parallel width
`define SLC_GPIO_ALL      10'h03FF
`define SLC_GPIO_W12      10'h03FC
`define SLC_GPIO_W14      10'h03F0
`define SLC_GPIO_W16      10'h03C0
`define SLC_GPIO_W18      10'h0300

`endif

/* File: core/slc_tri_gen.v */
`timescale 1ns/100ps
`include "slc_regs.vh"

// ****************************************
// Triangular center-spread profile
// ****************************************
module slc_tri_gen (
  input  wire                  clk_i,
  input  wire                  rstn_i,
  input  wire                  en_i,
  input  wire [`SLC_DIV_W-1:0] div_i,
  output reg  [`SLC_TRI_W-1:0] tri_o
);

  reg  [`SLC_DIV_W-1:0] phase_r;
  reg  [`SLC_DIV_W-1:0] phase_nxt;
  wire [`SLC_DIV_W-1:0] half;
  wire [`SLC_DIV_W-1:0] down;

  assign half = {1'b0, div_i[`SLC_DIV_W-1:1]};
  assign down = div_i - phase_r;

  always @* begin
    phase_nxt = phase_r + 12'h001;
    if (!en_i || div_i == 12'h000 || phase_r >= div_i - 12'h001) begin
      phase_nxt = 12'h000; // see R25
    end
  end

  // Rises for half a period and falls for the other half
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      phase_r <= 12'h000;
      tri_o   <= 11'h000;
    end else begin
      phase_r <= phase_nxt;
      if (!en_i) begin
        tri_o <= 11'h000;
      end else if (phase_r < half) begin
        tri_o <= phase_r[`SLC_TRI_W-1:0]; // see R25
      end else begin
        tri_o <= down[`SLC_TRI_W-1:0]; // see R25
      end
    end
  end

endmodule

/* File: bench/slc_mode_cfg_sva.sv */
`timescale 1ns/100ps
// ****************************************
// Port checks for the mode and status logic
// ****************************************
module slc_mode_cfg_sva (
  input wire       CORE_CLK_I,
  input wire       RSTN_I,
  input wire       PKT_VALID_I,
  input wire       PKT_FOR_LINK_I,
  input wire       I2C_RESP_VALID_I,
  input wire       LOCKED_I,
  input wire       SHUTDOWN_I,
  input wire       MODE_WE_I,
  input wire [9:0] GPIO_AVAIL_O,
  input wire [9:0] GPIO_OUT_O,
  input wire [9:0] GPIO_OE_O,
  input wire       PERIPHERAL_ENABLE_O,
  input wire       INTERFACE_SELECT_O,
  input wire       BYPASS_MODE_O,
  input wire       CC_OPEN_O,
  input wire       STO_EXPIRED_O,
  input wire       I2C_FWD_O,
  input wire       UART_RESP_O,
  input wire       LINK_REG_ACCESS_O,
  input wire       LOCK_O,
  input wire       LOCK_OE_O,
  input wire       ERROR_O,
  input wire       ERROR_OE_O
);
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  od_low_a: assert property (!LOCK_O && !ERROR_O)
    else $error("status pin driven high");
  lock_rel_a: assert property ($past(RSTN_I) |->
    LOCK_OE_O == $past(!SHUTDOWN_I && !LOCKED_I)) else $error("lock pull wrong");
  shut_rel_a: assert property ($past(RSTN_I && SHUTDOWN_I) |->
    !LOCK_OE_O && !ERROR_OE_O) else $error("status pulled in shutdown");
  gpio_mask_a: assert property (((GPIO_OE_O | GPIO_OUT_O) & ~GPIO_AVAIL_O) == 10'h000)
    else $error("unavailable gpio driven");
  fwd_route_a: assert property (I2C_FWD_O == $past(RSTN_I && PKT_VALID_I &&
    !PKT_FOR_LINK_I && PERIPHERAL_ENABLE_O && INTERFACE_SELECT_O)) else $error("i2c forward wrong");
  resp_route_a: assert property (UART_RESP_O == $past(RSTN_I && I2C_RESP_VALID_I &&
    PERIPHERAL_ENABLE_O && INTERFACE_SELECT_O)) else $error("uart response wrong");
  link_block_a: assert property (LINK_REG_ACCESS_O |->
    $past(PKT_VALID_I && PKT_FOR_LINK_I && !BYPASS_MODE_O)) else $error("link access wrong");
  bypass_sel_a: assert property (BYPASS_MODE_O |->
    PERIPHERAL_ENABLE_O && !INTERFACE_SELECT_O) else $error("bypass without selection");
  sto_close_a: assert property (STO_EXPIRED_O |-> !CC_OPEN_O && $past(CC_OPEN_O))
    else $error("expiry without close");
  reset_mode_a: assert property ($rose(RSTN_I) |->
    INTERFACE_SELECT_O && !PERIPHERAL_ENABLE_O) else $error("reset mode wrong");
  pe_drop_a: assert property ($fell(PERIPHERAL_ENABLE_O) |->
    $past(MODE_WE_I || BYPASS_MODE_O)) else $error("enable dropped outside bypass");
endmodule

/* File: bench/slc_ecu_model.sv */
`timescale 1ns/100ps
// ****************************************
// Controller side of the control channel
// ****************************************
module slc_ecu_model (
  input  wire clk_i,
  input  wire tick_en_i,
  output reg  mode_we_o,
  output reg  pe_o,
  output reg  is_o,
  output reg  tick_o,
  output reg  act_o
);
  reg [1:0] div_r;
  initial begin
    {mode_we_o, pe_o, is_o, act_o} = 4'h0;
    div_r = 2'h0;
  end
  // A bit time of 4 clocks keeps return timeouts short
  always @(negedge clk_i) begin
    div_r <= div_r + 2'h1;
    tick_o <= tick_en_i && (div_r == 2'h3);
  end
  // Staying in bypass is done with return code 0
  task mode_wr(input pe, input is_v);
    begin
      @(negedge clk_i);
      pe_o = pe;
      is_o = is_v;
      mode_we_o = 1'b1;
      @(negedge clk_i);
      mode_we_o = 1'b0;
    end
  endtask
  task poke;
    begin
      @(negedge clk_i);
      act_o = 1'b1;
      @(negedge clk_i);
      act_o = 1'b0;
    end
  endtask
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  reg         clk, rstn, vs, hs, vs_r, hs_r, gwe, lk, er, sd, pv, pfl, rv, ten, peer, ccc;
  reg  [2:0]  sp, bo, pw, wl, bypass_return_timeout;
  reg  [1:0]  sr, pr;
  reg  [9:0]  gdir, gwd, gin;
  reg  [3:0]  pre, cnt;
  integer     err_total, checks, seed, i, n, mx;
  wire        mwe, mpe, mis, tick, act, sp_en, hso, pe, is, byp, cco, fwd, rsp, lra, lko, lkoe;
  wire        eroe;
  wire [8:0]  sp_pct;
  wire [6:0]  bo_pct;
  wire [11:0] mdiv;
  wire [9:0]  gav, gout, goe, glev;
  wire [10:0] sptri;
  // Shared lock line with one pull-up and a second device on it
  wire        lock_bus = !((lkoe && !lko) || peer);

  slc_ecu_model ecu (.clk_i(clk), .tick_en_i(ten), .mode_we_o(mwe), .pe_o(mpe), .is_o(mis),
    .tick_o(tick), .act_o(act));
  slc_mode_cfg dut (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .SPREAD_SEL_I(sp), .BOOST_SEL_I(bo), .PWIDTH_I(pw),
    .WORD_LEN_I(wl), .SERIAL_RATE_RANGE_I(sr), .PIXEL_RATE_RANGE_I(pr),
    .VSYNC_RISE_SEL_I(vs_r), .HSYNC_RISE_SEL_I(hs_r), .VSYNC_I(vs), .HSYNC_I(hs),
    .GPIO_DIR_I(gdir), .GPIO_WDATA_I(gwd), .GPIO_WE_I(gwe), .GPIO_IN_I(gin),
    .PERIPHERAL_ENABLE_I(mpe), .INTERFACE_SELECT_I(mis), .MODE_WE_I(mwe),
    .BYPASS_RETURN_TIMEOUT_I(bypass_return_timeout), .UART_BIT_TICK_I(tick), .ECU_ACTIVITY_I(act),
    .START_TIMEOUT_PRESCALE_I(pre), .START_TIMEOUT_COUNT_I(cnt), .CC_CLOSE_I(ccc),
    .PKT_VALID_I(pv), .PKT_FOR_LINK_I(pfl), .I2C_RESP_VALID_I(rv), .LOCKED_I(lk),
    .ERR_I(er), .SHUTDOWN_I(sd), .SPREAD_EN_O(sp_en), .SPREAD_PCT_X100_O(sp_pct),
    .BOOST_PCT_O(bo_pct), .MOD_DIV_O(mdiv), .SPREAD_TRI_O(sptri), .HSYNC_O(hso),
    .GPIO_AVAIL_O(gav), .GPIO_OUT_O(gout), .GPIO_OE_O(goe), .GPIO_LEVEL_O(glev),
    .PERIPHERAL_ENABLE_O(pe), .INTERFACE_SELECT_O(is), .BYPASS_MODE_O(byp),
    .CC_OPEN_O(cco), .STO_EXPIRED_O(), .I2C_FWD_O(fwd), .UART_RESP_O(rsp),
    .LINK_REG_ACCESS_O(lra), .LOCK_O(lko), .LOCK_OE_O(lkoe), .ERROR_O(), .ERROR_OE_O(eroe));

  always #12.5 clk = ~clk;

  task check(input [95:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s expected %0d seen %0d", nm, exp, seen);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(negedge clk);
  endtask
  function [8:0] sp_exp(input [2:0] c);
    case (c)
      3'h1: sp_exp = 9'h096;
      3'h2: sp_exp = 9'h0AF;
      3'h3: sp_exp = 9'h0C8;
      3'h5: sp_exp = 9'h12C;
      3'h6: sp_exp = 9'h15E;
      3'h7: sp_exp = 9'h190;
      default: sp_exp = 9'h000;
    endcase
  endfunction
  function [6:0] bo_exp(input [2:0] c);
    case (c)
      3'h1: bo_exp = 7'h28;
      3'h2: bo_exp = 7'h3C;
      3'h3: bo_exp = 7'h50;
      3'h4: bo_exp = 7'h64;
      3'h7: bo_exp = 7'h00;
      default: bo_exp = 7'h14;
    endcase
  endfunction
  function [9:0] msk(input [2:0] w);
    case (w)
      3'h0: msk = 10'h3FF;
      3'h1: msk = 10'h3FC;
      3'h2: msk = 10'h3F0;
      3'h3: msk = 10'h3C0;
      default: msk = 10'h300;
    endcase
  endfunction
  task div_chk(input [2:0] w, input [1:0] s, input [1:0] p, input [11:0] e);
    begin
      {wl, sr, pr} = {w, s, p};
      cyc(2);
      check("mod_div", mdiv, e);
    end
  endtask
  task sto_run(input [3:0] p, input [3:0] c, input r);
    integer e;
    begin
      e = ((p < 4'h5) ? 16 : (1 << p)) * (c + 1);
      {pre, cnt, vs_r, vs} = {p, c, r, !r};
      cyc(6);
      vs = r;
      n = 0;
      while (cco !== 1'b1 && n < 12) begin
        @(negedge clk);
        n = n + 1;
      end
      check("cc_open", cco, 1);
      n = 0;
      while (cco === 1'b1 && n < 2 * e + 20) begin
        @(negedge clk);
        n = n + 1;
      end
      check("sto_len", n + 4 >= e && n <= e + 4, 1);
    end
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {vs, hs, vs_r, hs_r, gwe, lk, er, sd, pv, pfl, rv, ten, peer, ccc} = 14'h0000;
    {sp, bo, pw, wl, bypass_return_timeout, sr, pr, gdir, gwd, gin, pre, cnt} = 57'h0;
    seed = 20;
    err_total = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    check("pe_rst", pe, 0);
    check("is_rst", is, 1);
    for (i = 0; i < 8; i = i + 1) begin
      {sp, bo} = {i[2:0], i[2:0]};
      @(negedge clk);
      check("spread", sp_pct, sp_exp(sp));
      check("spread_en", sp_en, sp[1:0] != 2'h0);
      check("boost", bo_pct, bo_exp(bo));
    end
    // High pixel ranges allow at most 2 percent spread
    sp = 3'h3;
    div_chk(3'h0, 2'h3, 2'h3, 12'hAA8);
    div_chk(3'h4, 2'h3, 2'h3, 12'h660);
    div_chk(3'h1, 2'h2, 2'h1, 12'h3F0);
    div_chk(3'h2, 2'h1, 2'h1, 12'h334);
    div_chk(3'h4, 2'h0, 2'h0, 12'h000);
    div_chk(3'h3, 2'h0, 2'h0, 12'h228);
    // Wait for the triangle to reach zero, then measure one period and its peak
    n = 0;
    while (sptri !== 11'h000 && n < 1200) begin
      @(negedge clk);
      n = n + 1;
    end
    n = 0;
    mx = 0;
    @(negedge clk);
    while (sptri !== 11'h000 && n < 1200) begin
      if (sptri > mx)
        mx = sptri;
      @(negedge clk);
      n = n + 1;
    end
    check("tri_period", n + 1, 552);
    check("tri_peak", mx, 276);
    // Low pixel range keeps every spread code legal
    pr = 2'h0;
    $display("decode done");
    for (i = 0; i < 5; i = i + 1) begin
      pw = i[2:0];
      gdir = 10'h3FF;
      cyc(2);
      gwd = $random(seed);
      gwe = 1'b1;
      @(negedge clk);
      gwe = 1'b0;
      check("avail", gav, msk(pw));
      check("oe", goe, msk(pw));
      check("out", gout, gwd & msk(pw));
      gdir = 10'h000;
      gin = $random(seed);
      cyc(4);
      check("in_level", glev & msk(pw), gin & msk(pw));
    end
    $display("gpio done");
    for (i = 0; i < 3; i = i + 1) begin
      ecu.mode_wr(i != 1, i != 2);
      check("bypass", byp, i == 2);
      pv = 1'b1;
      repeat (8) begin
        {pfl, rv} = $random(seed);
        @(negedge clk);
        check("i2c_fwd", fwd, !pfl && i == 0);
        check("uart_resp", rsp, rv && i == 0);
        check("link_acc", lra, pfl && i != 2);
      end
      pv = 1'b0;
    end
    bypass_return_timeout = 3'h1;
    ten = 1'b1;
    ecu.mode_wr(1'b1, 1'b0);
    cyc(40);
    ecu.poke;
    n = 0;
    while (pe === 1'b1 && n < 200) begin
      @(negedge clk);
      n = n + 1;
    end
    check("cto_wait", n >= 56 && n <= 72, 1);
    check("byp_ret", byp, 0);
    bypass_return_timeout = 3'h0;
    ecu.mode_wr(1'b1, 1'b0);
    cyc(150);
    check("cto_lock", pe, 1);
    ecu.mode_wr(1'b0, 1'b1);
    ten = 1'b0;
    $display("mode done");
    for (i = 0; i < 16; i = i + 1) begin
      {peer, sd, er, lk} = i[3:0];
      @(negedge clk);
      check("lock_oe", lkoe, !sd && !lk);
      check("err_oe", eroe, !sd && er);
      check("lock_bus", lock_bus, (sd || lk) && !peer);
    end
    for (i = 0; i < 4; i = i + 1) begin
      {hs, hs_r} = i[1:0];
      cyc(4);
      check("hsync", hso, hs ^ hs_r);
    end
    $display("status done");
    for (i = 3; i < 7; i = i + 1)
      sto_run(i[3:0], 4'h0, 1'b0);
    sto_run(4'h0, 4'h2, 1'b0);
    sto_run(4'h5, 4'h1, 1'b1);
    vs = 1'b0;
    cyc(12);
    check("fall_ignored", cco, 0);
    // Activity stops the start timer, so only a close request ends the channel
    {pre, cnt, vs_r, vs} = {4'h0, 4'h0, 1'b0, 1'b1};
    cyc(4);
    vs = 1'b0;
    cyc(6);
    ecu.poke;
    cyc(40);
    check("sto_stop", cco, 1);
    ccc = 1'b1;
    @(negedge clk);
    ccc = 1'b0;
    check("cc_close", cco, 0);
    $display("timeout done");
    results;
  end
endmodule

bind slc_mode_cfg slc_mode_cfg_sva chk (.*);
